//--- hw/fasog_core.v
// Purpose: address forming, space selection and one-time-programmable guard of a serial flash
// Assumes: serial clock much slower than core_clk (at least 4 core cycles per phase)
// Notes:   main array contents are not stored; program attempts are checked and logged only
//
// What this block does
// - accept byte addresses up to 32 bits
// - 24-bit address alone reaches lowest 16 Mbytes
// - bank register supplies upper bits for legacy
// - extended bit makes legacy commands take 32 bits
// - newer commands always take 32-bit address
// - reset clears bank register, 24-bit mode
// - separate spaces indexed by full 32-bit address
// - 256 sectors of 256 kbytes from zero
// - instruction 9Fh returns identification space
// - identification space is read-only
// - 5Ah returns parameter space embedding identification
// - parameter space is read-only
// - 1024-byte otp, 32 regions of 32 bytes
// - lowest 16 bytes random, never programmable
// - lock bytes 10h-13h block locked regions
// - lock bits active low, region order
// - reserved bytes 14h-1Fh programmable until region 0 locked
// - delivered lock, reserved, user bytes read FF
// - lockdown bit blocks all otp programming
// - lockdown stays set until power-off or reset
// - blocked program attempt sets program-error flag
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "fasog_regs.vh"

module fasog_core #(
   parameter [63:0]  ID_VALUE    = 64'h0123456789abcdef, // arbitrary identity value
   parameter [63:0]  PARAM_HDR   = 64'h0000000850444653, // arbitrary parameter header
   parameter [127:0] RAND_VALUE  = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0 // arbitrary
) (
   input  wire        core_clk,
   input  wire        nrst,
   input  wire        sck,
   input  wire        csN,
   input  wire        mosi,
   output reg         miso,
   output reg         misoOeN,
   input  wire [7:0]  regAddr,
   input  wire [31:0] regWdata,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [31:0] regRdata,
   output reg         progErr
);

   localparam [2:0] ST_CMD   = 3'd0;
   localparam [2:0] ST_ADDR  = 3'd1;
   localparam [2:0] ST_DUMMY = 3'd2;
   localparam [2:0] ST_DIN   = 3'd3;
   localparam [2:0] ST_DOUT  = 3'd4;
   localparam [2:0] ST_IGN   = 3'd5;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: a level counts once the second and third stages agree
   reg  [2:0]  sckS_r;
   reg  [2:0]  csS_r;
   reg  [2:0]  mosiS_r;
   reg         sckF_r;
   reg         csF_r;
   reg         mosiF_r;
   wire        sckAgree  = (sckS_r[1] == sckS_r[2]);
   wire        csAgree   = (csS_r[1] == csS_r[2]);
   wire        mosiNow   = (mosiS_r[1] == mosiS_r[2]) ? mosiS_r[2] : mosiF_r;
   wire        csNow     = csAgree ? csS_r[2] : csF_r;
   // edges come from the filtered level, so one odd sample cannot fake a clock
   wire        sckRise   = sckAgree && sckS_r[2] && !sckF_r;
   wire        sckFall   = sckAgree && !sckS_r[2] && sckF_r;

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sckS_r  <= 3'h0;
         csS_r   <= 3'h7;
         mosiS_r <= 3'h0;
         sckF_r  <= 1'b0;
         csF_r   <= 1'b1;
         mosiF_r <= 1'b0;
      end else begin
         sckS_r  <= {sckS_r[1:0], sck};
         csS_r   <= {csS_r[1:0], csN};
         mosiS_r <= {mosiS_r[1:0], mosi};
         if (sckAgree) begin
            sckF_r <= sckS_r[2];
         end
         csF_r   <= csNow;
         mosiF_r <= mosiNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // otp array; contents survive reset, as a non-volatile store would
   reg  [7:0]  otpMem [0:`FASOG_OTP_BYTES-1];
   reg         otpWe_r;
   reg  [9:0]  otpWa_r;
   reg  [7:0]  otpWd_r;
   integer     i;

   initial begin
      for (i = 0; i < `FASOG_OTP_BYTES; i = i + 1) begin
         if (i < `FASOG_OTP_RAND_BYTES) begin
            otpMem[i] = RAND_VALUE[8*i +: 8];
         end else begin
            otpMem[i] = `FASOG_ERASED;
         end
      end
   end

   // programming only clears bits, like a real cell
   always @(posedge core_clk) begin
      if (otpWe_r) begin
         otpMem[otpWa_r] <= otpMem[otpWa_r] & otpWd_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control state
   reg  [2:0]  state_r;
   reg  [5:0]  bitCnt_r;
   reg  [5:0]  addrBits_r;
   reg  [31:0] shIn_r;
   reg  [7:0]  cmd_r;
   reg  [31:0] ptr_r;
   reg  [7:0]  shOut_r;
   reg         loadPend_r;
   reg  [7:0]  bank_r;
   reg         lockdown_r;
   reg  [16:0] prot_r;
   reg  [31:0] lastProg_r;

   wire [31:0] fullIn   = {shIn_r[30:0], mosiNow};
   wire [7:0]  byteIn   = fullIn[7:0];
   wire [5:0]  bitNext  = bitCnt_r + 6'd1;
   wire        extMode  = bank_r[`FASOG_BANK_EXT_BIT];
   // high address byte in legacy mode comes from the bank register
   wire [31:0] formed   = (addrBits_r == `FASOG_LEGACY_BITS) ?
                          {1'b0, bank_r[6:0], fullIn[23:0]} : fullIn;

   // otp guard
   // lock bits are read live, so a lock written mid-frame bites on the next byte
   wire [4:0]  region    = ptr_r[9:5];
   wire [7:0]  lockByte  = otpMem[`FASOG_OTP_LOCK_BASE + {8'h00, region[4:3]}];
   wire        regionOk  = lockByte[region[2:0]];
   wire        otpBlocked = lockdown_r
                         || (ptr_r[31:10] != 22'h0)
                         || (ptr_r[9:4] == 6'h00)
                         || !regionOk;

   // main array guard: 256 sectors of 256 kbytes
   wire [7:0]  sector   = ptr_r[`FASOG_SECT_LSB+7:`FASOG_SECT_LSB];
   wire        sectProt = prot_r[`FASOG_PROT_EN_BIT]
                          && (sector >= prot_r[7:0]) && (sector <= prot_r[15:8]);
   wire        mainBlocked = (ptr_r[31:`FASOG_ARRAY_MSB+1] != 6'h0) || sectProt;

   // read-only spaces come from constants, so no path writes them
   wire [7:0]  idByte    = (ptr_r[31:3] == 29'h0) ?
                           ID_VALUE[{ptr_r[2:0], 3'b000} +: 8] : `FASOG_ERASED;
   wire [7:0]  paramByte = (ptr_r[31:4] != 28'h0) ? `FASOG_ERASED :
                           ptr_r[3] ? ID_VALUE[{ptr_r[2:0], 3'b000} +: 8] :
                           PARAM_HDR[{ptr_r[2:0], 3'b000} +: 8];
   wire [7:0]  otpByte   = (ptr_r[31:10] == 22'h0) ? otpMem[ptr_r[9:0]] : `FASOG_ERASED;

   // bytes past the end of a read-only table read as erased and never wrap
   reg  [7:0]  srcByte;
   always @* begin
      case (cmd_r)
         `FASOG_CMD_READ_IDENT:  srcByte = idByte;
         `FASOG_CMD_READ_PARAMS: srcByte = paramByte;
         `FASOG_CMD_OTP_READ:    srcByte = otpByte;
         `FASOG_CMD_BANK_READ:   srcByte = bank_r;
         `FASOG_CMD_STAT_READ:   srcByte = {7'h00, progErr};
         default:                srcByte = `FASOG_ERASED;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port decode
   wire        swWrBank = regWr && (regAddr == `FASOG_REG_BANK);
   wire        swWrCfg  = regWr && (regAddr == `FASOG_REG_CFG1);
   wire        swWrStat = regWr && (regAddr == `FASOG_REG_STATUS);
   wire        swWrProt = regWr && (regAddr == `FASOG_REG_PROT);

   reg  [31:0] rdVal;
   always @* begin
      if (regAddr == `FASOG_REG_BANK) begin
         rdVal = {24'h0, bank_r};
      end else if (regAddr == `FASOG_REG_CFG1) begin
         rdVal = {31'h0, lockdown_r};
      end else if (regAddr == `FASOG_REG_STATUS) begin
         rdVal = {30'h0, (state_r != ST_CMD), progErr};
      end else if (regAddr == `FASOG_REG_ADDR) begin
         rdVal = ptr_r;
      end else if (regAddr == `FASOG_REG_PROT) begin
         rdVal = {15'h0, prot_r};
      end else if (regAddr == `FASOG_REG_LASTPROG) begin
         rdVal = lastProg_r;
      end else begin
         rdVal = 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial command engine and the registers it shares with software
   reg         errSet;
   reg         errClr;
   always @* begin
      errSet = 1'b0;
      errClr = swWrStat && regWdata[`FASOG_STAT_PERR_BIT];
      if (sckRise && !csNow) begin
         if (state_r == ST_CMD && bitCnt_r == 6'd7 && byteIn == `FASOG_CMD_CLEAR_STAT) begin
            errClr = 1'b1;
         end
         if (state_r == ST_DIN && bitCnt_r == 6'd7) begin
            if (cmd_r == `FASOG_CMD_OTP_PROG && otpBlocked) begin
               errSet = 1'b1;
            end
            if ((cmd_r == `FASOG_CMD_PROG3 || cmd_r == `FASOG_CMD_PROG4) && mainBlocked) begin
               errSet = 1'b1;
            end
         end
      end
   end

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_r    <= ST_CMD;
         bitCnt_r   <= 6'h00;
         addrBits_r <= `FASOG_LEGACY_BITS;
         shIn_r     <= 32'h0;
         cmd_r      <= 8'h00;
         ptr_r      <= 32'h0;
         shOut_r    <= 8'h00;
         loadPend_r <= 1'b0;
         bank_r     <= `FASOG_BANK_RST;
         lockdown_r <= 1'b0;
         prot_r     <= `FASOG_PROT_RST;
         lastProg_r <= 32'h0;
         progErr    <= 1'b0;
         otpWe_r    <= 1'b0;
         otpWa_r    <= 10'h000;
         otpWd_r    <= 8'h00;
         miso       <= 1'b0;
         misoOeN    <= 1'b1;
         regRdata   <= 32'h0;
      end else begin
         otpWe_r  <= 1'b0;
         // read data stands one cycle only, so a stale word never looks fresh
         regRdata <= regRd ? rdVal : 32'h0;
         progErr  <= errSet | (progErr & ~errClr);                          // set wins
         if (swWrProt) begin
            prot_r <= regWdata[16:0];
         end
         // only reset clears lockdown; writing zero is ignored on purpose
         if (swWrCfg && regWdata[`FASOG_CFG_LOCKDOWN_BIT]) begin
            lockdown_r <= 1'b1;
         end
         if (swWrBank) begin
            bank_r <= regWdata[7:0];
         end
         // next byte loads a cycle after the last rise, well before its first fall
         if (loadPend_r) begin
            shOut_r    <= srcByte;
            loadPend_r <= 1'b0;
         end
         // deselect aborts a frame; a half-shifted byte is dropped, never applied
         if (csNow) begin
            state_r  <= ST_CMD;
            bitCnt_r <= 6'h00;
            misoOeN  <= 1'b1;
         end else if (sckFall && state_r == ST_DOUT) begin
            miso    <= shOut_r[7];
            shOut_r <= {shOut_r[6:0], 1'b0};
            misoOeN <= 1'b0;
         end else if (sckRise) begin
            shIn_r   <= fullIn;
            bitCnt_r <= bitNext;
            case (state_r)
               ST_CMD: begin
                  if (bitCnt_r == 6'd7) begin
                     cmd_r    <= byteIn;
                     bitCnt_r <= 6'h00;
                     case (byteIn)
                        `FASOG_CMD_READ_IDENT, `FASOG_CMD_BANK_READ,
                        `FASOG_CMD_STAT_READ: begin
                           state_r    <= ST_DOUT;
                           ptr_r      <= 32'h0;
                           loadPend_r <= 1'b1;
                        end
                        `FASOG_CMD_READ_PARAMS, `FASOG_CMD_OTP_READ,
                        `FASOG_CMD_OTP_PROG, `FASOG_CMD_PROG3: begin
                           state_r    <= ST_ADDR;
                           addrBits_r <= extMode ? `FASOG_FULL_BITS
                                                 : `FASOG_LEGACY_BITS;
                        end
                        `FASOG_CMD_PROG4: begin
                           state_r    <= ST_ADDR;
                           addrBits_r <= `FASOG_FULL_BITS;
                        end
                        `FASOG_CMD_BANK_WRITE, `FASOG_CMD_CFG_WRITE: begin
                           state_r <= ST_DIN;
                        end
                        default: begin
                           state_r <= ST_IGN;
                        end
                     endcase
                  end
               end
               ST_ADDR: begin
                  if (bitNext == addrBits_r) begin
                     ptr_r    <= formed;
                     bitCnt_r <= 6'h00;
                     if (cmd_r == `FASOG_CMD_READ_PARAMS || cmd_r == `FASOG_CMD_OTP_READ) begin
                        state_r <= ST_DUMMY;
                     end else begin
                        state_r <= ST_DIN;
                     end
                  end
               end
               ST_DUMMY: begin
                  if (bitCnt_r == 6'd7) begin
                     state_r    <= ST_DOUT;
                     bitCnt_r   <= 6'h00;
                     loadPend_r <= 1'b1;
                  end
               end
               // programming walks the pointer, so each byte is guarded on its own
               ST_DIN: begin
                  if (bitCnt_r == 6'd7) begin
                     bitCnt_r <= 6'h00;
                     ptr_r    <= ptr_r + 32'd1;
                     case (cmd_r)
                        `FASOG_CMD_BANK_WRITE: begin
                           bank_r  <= byteIn;
                           state_r <= ST_IGN;
                        end
                        `FASOG_CMD_CFG_WRITE: begin
                           if (byteIn[`FASOG_CFG_LOCKDOWN_BIT]) begin
                              lockdown_r <= 1'b1;
                           end
                           state_r <= ST_IGN;
                        end
                        `FASOG_CMD_OTP_PROG: begin
                           otpWe_r <= !otpBlocked;
                           otpWa_r <= ptr_r[9:0];
                           otpWd_r <= byteIn;
                        end
                        default: begin
                           if (!mainBlocked) begin
                              lastProg_r <= ptr_r;
                           end
                        end
                     endcase
                  end
               end
               ST_DOUT: begin
                  if (bitCnt_r == 6'd7) begin
                     bitCnt_r   <= 6'h00;
                     ptr_r      <= ptr_r + 32'd1;
                     loadPend_r <= 1'b1;
                  end
               end
               default: begin
                  bitCnt_r <= 6'h00;
               end
            endcase
         end
      end
   end

endmodule

//--- hw/fasog_regs.vh
// Purpose: constants of the flash address space and one-time-programmable guard
// Assumes: included by fasog_core.v and also by the dv property checker and bench
// Notes:   register offsets are byte addresses on the plain register port
`ifndef FASOG_REGS_VH
`define FASOG_REGS_VH

// serial instruction codes
`define FASOG_CMD_READ_IDENT   8'h9f
`define FASOG_CMD_READ_PARAMS  8'h5a
`define FASOG_CMD_OTP_READ     8'h4b
`define FASOG_CMD_OTP_PROG     8'h42
`define FASOG_CMD_PROG3        8'h02
`define FASOG_CMD_PROG4        8'h12
`define FASOG_CMD_BANK_WRITE   8'h17
`define FASOG_CMD_BANK_READ    8'h16
`define FASOG_CMD_CFG_WRITE    8'h01
`define FASOG_CMD_STAT_READ    8'h05
`define FASOG_CMD_CLEAR_STAT   8'h30

// software register byte offsets
`define FASOG_REG_BANK         8'h00
`define FASOG_REG_CFG1         8'h04
`define FASOG_REG_STATUS       8'h08
`define FASOG_REG_ADDR         8'h0c
`define FASOG_REG_PROT         8'h10
`define FASOG_REG_LASTPROG     8'h14

// fields
`define FASOG_BANK_EXT_BIT     7
`define FASOG_CFG_LOCKDOWN_BIT 0
`define FASOG_STAT_PERR_BIT    0
`define FASOG_STAT_BUSY_BIT    1
`define FASOG_PROT_EN_BIT      16

// reset values
`define FASOG_BANK_RST         8'h00
`define FASOG_PROT_RST         17'h00000

// address geometry
`define FASOG_LEGACY_BITS      6'd24
`define FASOG_FULL_BITS        6'd32
`define FASOG_SECT_LSB         18
`define FASOG_ARRAY_MSB        25
`define FASOG_OTP_BYTES        1024
`define FASOG_OTP_RAND_BYTES   16
`define FASOG_OTP_LOCK_BASE    10'h010
`define FASOG_ERASED           8'hff

`endif

//--- dv/fasog_core_properties.sv
// Purpose: port checks on the flash address guard
// Assumes: serial link much slower than core_clk
// Notes:   bound to every fasog_core
`timescale 1ns/1ps
`include "fasog_regs.vh"
module fasog_core_properties (
   input wire        core_clk,
   input wire        nrst,
   input wire        sck,
   input wire        csN,
   input wire        mosi,
   input wire        miso,
   input wire        misoOeN,
   input wire [7:0]  regAddr,
   input wire [31:0] regWdata,
   input wire        regWr,
   input wire        regRd,
   input wire [31:0] regRdata,
   input wire        progErr
);
   reg bankFresh_r;
   reg lockSeen_r;
   // a serial frame may rewrite the bank, so freshness ends there too
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bankFresh_r <= 1'b1;
         lockSeen_r  <= 1'b0;
      end else begin
         if ((regWr && regAddr == `FASOG_REG_BANK) || !csN)
            bankFresh_r <= 1'b0;
         if (regWr && regAddr == `FASOG_REG_CFG1 && regWdata[0])
            lockSeen_r <= 1'b1;
      end
   end
   ////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   chk_reset_quiet: assert property ($rose(nrst) |-> !progErr && misoOeN)
      else $error("outputs busy right after reset");
   chk_bank_fresh: assert property (
         regRd && regAddr == `FASOG_REG_BANK && bankFresh_r |=> regRdata[7:0] == 8'h00)
      else $error("bank not zero after reset");
   chk_bank_back: assert property (
         regWr && regAddr == `FASOG_REG_BANK ##1 regRd && regAddr == `FASOG_REG_BANK && csN
         |=> regRdata[7:0] == $past(regWdata[7:0], 2))
      else $error("bank readback differs");
   chk_status_flag: assert property (
         regRd && regAddr == `FASOG_REG_STATUS |=> regRdata[0] == $past(progErr))
      else $error("status bit differs from flag");
   chk_err_frame: assert property ($rose(progErr) |-> !$past(csN))
      else $error("program error outside a frame");
   chk_err_sticky: assert property (
         progErr && csN && !(regWr && regAddr == `FASOG_REG_STATUS && regWdata[0])
         |=> progErr)
      else $error("program error dropped");
   chk_lock_kept: assert property (
         regRd && regAddr == `FASOG_REG_CFG1 && lockSeen_r |=> regRdata[0])
      else $error("lockdown cleared");
   chk_last_range: assert property (
         regRd && regAddr == `FASOG_REG_LASTPROG |=> regRdata[31:26] == 6'h00)
      else $error("accepted program beyond array");
   chk_oe_release: assert property ($rose(csN) |-> ##[1:8] misoOeN)
      else $error("data pin still driven after deselect");
   cover property ($rose(progErr));
   cover property (!misoOeN);
   cover property (regRd && regAddr == `FASOG_REG_CFG1 && lockSeen_r);
endmodule
bind fasog_core fasog_core_properties i_fasog_core_properties (
   .core_clk(core_clk), .nrst(nrst), .sck(sck), .csN(csN), .mosi(mosi), .miso(miso),
   .misoOeN(misoOeN), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .regRd(regRd), .regRdata(regRdata), .progErr(progErr));

//--- dv/fasog_host_model.sv
// Purpose: host serial controller driving the flash guard
// Assumes: mode 0, 160 ns serial period, msb first
// Notes:   sck rests low between frames
`timescale 1ns/1ps
module fasog_host_model (
   output logic csN,
   output logic sck,
   output logic mosi,
   input  wire  miso
);
   initial begin
      csN  = 1'b1;
      sck  = 1'b0;
      mosi = 1'b0;
   end
   // miso is taken late in the high phase, well clear of its change after a fall
   task automatic frame(input logic [255:0] tx, input int n, output logic [255:0] rx);
      rx = '0;
      #7 csN = 1'b0;
      #80;
      for (int i = n - 1; i >= 0; i--) begin
         mosi = tx[i];
         #80 sck = 1'b1;
         #79 rx = {rx[254:0], miso};
         #1 sck = 1'b0;
      end
      #80 csN = 1'b1;
      mosi = ~mosi; // no stale level once released
      #120;
   endtask
endmodule

//--- dv/tb.sv
// Purpose: self-checking bench for the flash address guard
// Assumes: host model drives the link, bench drives the register port
// Notes:   address forming is seen through LASTPROG
`timescale 1ns/1ps
`include "fasog_regs.vh"
module tb;
   typedef struct packed {
      logic [7:0]  bank;
      logic [7:0]  cmd;
      logic [5:0]  abits;
      logic [31:0] addr;
      logic [7:0]  data;
      logic        err;
      logic [31:0] last;
   } fasog_row_t;
   localparam logic [63:0]  ID_V   = 64'h1122334455667788; // arbitrary
   localparam logic [63:0]  HDR_V  = 64'h0807060504030201; // arbitrary
   localparam logic [127:0] RAND_V = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f; // arbitrary
   logic         core_clk;
   logic         nrst;
   logic         sck;
   logic         csN;
   logic         mosi;
   logic         miso;
   logic         misoOeN;
   logic         misoLine;
   logic [7:0]   regAddr;
   logic [31:0]  regWdata;
   logic         regWr;
   logic         regRd;
   logic [31:0]  regRdata;
   logic         progErr;
   logic [31:0]  q;
   logic [255:0] rx;
   int           n_mismatch = 0;
   int           comparisons = 0;
   int           cycles = 0;
   logic [23:0]  otpA [3] = '{24'h00000f, 24'h000013, 24'h000020};
   logic [15:0]  otpE [3] = '{{RAND_V[127:120], 8'hfd}, 16'hff5a, 16'h5aff};
   fasog_row_t   rows [12] = '{
      '{8'h00, 8'h02, 6'd24, 32'h00ffffff, 8'h5a, 1'b0, 32'h00ffffff},
      '{8'h03, 8'h02, 6'd24, 32'h00000000, 8'h5a, 1'b0, 32'h03000000},
      '{8'h80, 8'h02, 6'd32, 32'h03fc0001, 8'h5a, 1'b0, 32'h03fc0001},
      '{8'h80, 8'h12, 6'd32, 32'h04000000, 8'h5a, 1'b1, 32'h0},
      '{8'h03, 8'h12, 6'd32, 32'h00000010, 8'h5a, 1'b0, 32'h00000010},
      '{8'h00, 8'h42, 6'd24, 32'h00000005, 8'h00, 1'b1, 32'h0},
      '{8'h00, 8'h42, 6'd24, 32'h00000400, 8'h00, 1'b1, 32'h0},
      '{8'h00, 8'h42, 6'd24, 32'h00000014, 8'h5a, 1'b0, 32'h0},
      '{8'h00, 8'h42, 6'd24, 32'h00000020, 8'h5a, 1'b0, 32'h0},
      '{8'h00, 8'h42, 6'd24, 32'h00000010, 8'hfd, 1'b0, 32'h0},
      '{8'h00, 8'h42, 6'd24, 32'h00000021, 8'h00, 1'b1, 32'h0},
      '{8'h00, 8'h42, 6'd24, 32'h000003ff, 8'h5a, 1'b0, 32'h0}};
   // undriven data pin read as high, never as the last bit
   assign misoLine = misoOeN ? 1'b1 : miso;
   fasog_core #(.ID_VALUE(ID_V), .PARAM_HDR(HDR_V), .RAND_VALUE(RAND_V)) i_fasog_core (
      .core_clk(core_clk), .nrst(nrst), .sck(sck), .csN(csN), .mosi(mosi), .miso(miso),
      .misoOeN(misoOeN), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .progErr(progErr));
   fasog_host_model i_fasog_host_model (.csN(csN), .sck(sck), .mosi(mosi), .miso(misoLine));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         finish_test();
      end
   end
   ////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bits(input logic [127:0] got, input logic [127:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t serial %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [63:0] swap(input logic [63:0] v);
      for (int i = 0; i < 8; i++)
         swap[8*i +: 8] = v[56-8*i +: 8];
   endfunction
   // register tasks start and end on a rising edge
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic wrFirst, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      if (wrFirst) begin
         regWr <= 1'b1;
         @(posedge core_clk);
         regWr <= 1'b0;
      end
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 q = regRdata;
      @(posedge core_clk);
   endtask
   task automatic xfer(input logic [255:0] tx, input int n);
      i_fasog_host_model.frame(tx, n, rx);
      @(posedge core_clk);
   endtask
   task automatic prog(input logic [7:0] c, input int ab, input logic [31:0] a,
                       input logic [7:0] d, input logic e);
      xfer((256'(c) << (ab + 8)) | (256'(a) << 8) | 256'(d), ab + 16);
      chk_word({31'h0, progErr}, {31'h0, e});
      reg_wr(`FASOG_REG_STATUS, 32'h1);
   endtask
   ////////////////////////////////
   initial begin
      nrst = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         reg_rd(8'(4 * i), 1'b0, 32'h0);
         chk_word(q, 32'h0);
      end
      chk_word({31'h0, misoOeN}, 32'h1);
      foreach (rows[i]) begin
         reg_rd(`FASOG_REG_BANK, 1'b1, {24'h0, rows[i].bank});
         chk_word(q, {24'h0, rows[i].bank});
         prog(rows[i].cmd, rows[i].abits, rows[i].addr, rows[i].data, rows[i].err);
         if (!rows[i].err && rows[i].cmd != 8'h42) begin
            reg_rd(`FASOG_REG_LASTPROG, 1'b0, 32'h0);
            chk_word(q, rows[i].last);
         end
      end
      reg_wr(`FASOG_REG_BANK, 32'h0);
      for (int i = 0; i < 3; i++) begin
         xfer({8'h4b, otpA[i], 8'h00, 16'h0}, 56);
         chk_bits(128'(rx[15:0]), 128'(otpE[i]));
      end
      xfer({8'h9f, 64'h0}, 72);
      chk_bits(128'(rx[63:0]), 128'(swap(ID_V)));
      xfer({8'h5a, 24'h0, 8'h0, 128'h0}, 168);
      chk_bits(rx[127:0], {swap(HDR_V), swap(ID_V)});
      reg_wr(`FASOG_REG_PROT, 32'h0001fffe);
      prog(8'h12, 32, 32'h03f80000, 8'h00, 1'b1);
      prog(8'h12, 32, 32'h03f7ffff, 8'h00, 1'b0);
      // boot code sets lockdown only after its own programming is done
      xfer({8'h01, 8'h01}, 16);
      prog(8'h42, 24, 32'h15, 8'h00, 1'b1);
      reg_wr(`FASOG_REG_CFG1, 32'h1);
      reg_wr(`FASOG_REG_CFG1, 32'h0);
      reg_rd(`FASOG_REG_CFG1, 1'b0, 32'h0);
      chk_word({31'h0, q[0]}, 32'h1);
      prog(8'h42, 24, 32'h16, 8'h00, 1'b1);
      reg_wr(`FASOG_REG_BANK, 32'h83);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      reg_rd(`FASOG_REG_BANK, 1'b0, 32'h0);
      chk_word(q, 32'h0);
      prog(8'h42, 24, 32'h16, 8'h00, 1'b0);
      xfer({8'h42, 24'h000005, 8'h00}, 40);
      chk_word({31'h0, progErr}, 32'h1);
      xfer({8'h05, 8'h00}, 16);
      chk_bits(128'(rx[7:0]), 128'h01);
      xfer(256'h30, 8);
      chk_word({31'h0, progErr}, 32'h0);
      xfer({8'h17, 8'h85}, 16);
      reg_rd(`FASOG_REG_BANK, 1'b0, 32'h0);
      chk_word(q, 32'h85);
      xfer({8'h16, 8'h00}, 16);
      chk_bits(128'(rx[7:0]), 128'h85);
      finish_test();
   end
endmodule
